// [adcs_pkg.sv]
// Shared constants and types of the converter control block.
// Assumes a single 20 MHz clock and a 32-bit APB register port.
package adcs_pkg;

  // Channel and result geometry
  localparam int unsigned CH_COUNT     = 24;
  localparam int unsigned CH_W         = 5;
  localparam int unsigned RES_W        = 10;
  localparam int unsigned PAD_W        = 6;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned SCAN_LEN     = 4;
  localparam logic [4:0]  CH_TOP       = 5'h17;
  localparam logic [4:0]  SCAN_FIRST_MAX = 5'h14;
  localparam logic [1:0]  SCAN_LAST_IDX  = 2'h3;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PINSEL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_RESULT = 8'h0C;

  // Control register fields
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_SCAN_BIT  = 1;
  localparam int unsigned CTRL_XFER_BIT  = 2;
  localparam int unsigned CTRL_CH_LSB    = 4;

  // Status register fields
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  localparam int unsigned STAT_OVR_BIT  = 2;
  localparam int unsigned STAT_CH_LSB   = 8;

  // Reset values
  localparam logic [4:0]  PINSEL_RST = 5'h00;
  localparam logic [4:0]  CH_RST     = 5'h00;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // Sequencer states
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT} adcs_seq_state_t;

endpackage

// [adcs_pin_map.sv]
// Analog pin enable map built from the analog pin count.
// Assumes the count comes from a register in the same clock domain.
`timescale 1ns/1ps
module adcs_pin_map import adcs_pkg::*; (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [CH_W-1:0]     analog_pin_select,
  output logic      [CH_COUNT-1:0] analog_en_q
);

  // Channels below the count are analog, one block from channel zero
  genvar g;
  generate
    for (g = 0; g < CH_COUNT; g++) begin : g_pin
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          analog_en_q[g] <= 1'b0;
        end else begin
          analog_en_q[g] <= (CH_W'(g) < analog_pin_select); // R1
        end
      end
    end
  endgenerate

  a_pin_block: assert property (@(posedge clk) disable iff (rst) // R1
    (analog_en_q[CH_COUNT-1:1] & ~analog_en_q[CH_COUNT-2:0]) == '0)
    else $error("analog pins not one block from channel zero");

endmodule

// [adcs_scan_seq.sv]
// Channel sequencer: one channel or a scan of four in a row.
// Assumes the analog core answers each start with one done pulse.
`timescale 1ns/1ps
module adcs_scan_seq import adcs_pkg::*; (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            go,
  input  wire logic            scan,
  input  wire logic [CH_W-1:0] first_ch,
  input  wire logic            conv_done,
  output logic                 start_q,
  output logic      [CH_W-1:0] chan_q,
  output logic                 busy_q
);

  adcs_seq_state_t state_q;
  logic [1:0]      idx_q;
  logic            scan_q;

  // Clamp start so the scan stays inside channels 0 to 23
  function automatic logic [CH_W-1:0] clamp_ch(input logic [CH_W-1:0] c,
                                               input logic            s);
    logic [CH_W-1:0] lim;
    lim = s ? SCAN_FIRST_MAX : CH_TOP;
    return (c > lim) ? lim : c;
  endfunction

  // Sequence state, channel and position in the scan
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= SEQ_IDLE;
      idx_q   <= 2'h0;
      scan_q  <= 1'b0;
      chan_q  <= CH_RST;
      start_q <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      start_q <= 1'b0;
      unique case (state_q)
        SEQ_IDLE: begin
          if (go) begin
            chan_q  <= clamp_ch(first_ch, scan); // R3
            scan_q  <= scan;
            idx_q   <= 2'h0;
            busy_q  <= 1'b1;
            state_q <= SEQ_ISSUE;
          end
        end
        SEQ_ISSUE: begin
          start_q <= 1'b1;
          state_q <= SEQ_WAIT;
        end
        SEQ_WAIT: begin
          if (conv_done) begin
            if (scan_q && idx_q != SCAN_LAST_IDX) begin
              chan_q  <= chan_q + 5'h01; // R3
              idx_q   <= idx_q + 2'h1;
              state_q <= SEQ_ISSUE;
            end else begin
              busy_q  <= 1'b0;
              state_q <= SEQ_IDLE;
            end
          end
        end
      endcase
    end
  end

  a_scan_next: assert property (@(posedge clk) disable iff (rst) // R3
    (state_q == SEQ_WAIT && conv_done && scan_q && idx_q != SCAN_LAST_IDX)
      |=> (chan_q == $past(chan_q) + 5'h01) ##1 start_q)
    else $error("scan did not move to the next channel");

  a_scan_range: assert property (@(posedge clk) disable iff (rst) // R3
    start_q |-> chan_q <= CH_TOP)
    else $error("conversion started outside channels 0 to 23");

endmodule

// [adcs_top.sv]
// Converter control: APB registers, pin map, sequencing, result word,
// completion events and transfer controller handshake.
// Assumes an analog core that converts the selected channel and
// returns ten bits with a one-cycle done pulse.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
// What this block does
// R1: Analog channels form one block from zero
// R2: Result sits left-justified, low six bits zero
// R3: Scan converts four consecutive channels 0 to 23
// R4: Reader fetches each result before the next; an unfetched result is overwritten and sets the overrun flag
// R5: Transfer controller may copy each result
// R6: Completion event after every channel result
module adcs_top import adcs_pkg::*; (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata_q,
  output logic                     pready_q,
  output logic                     pslverr_q,
  output logic      [CH_COUNT-1:0] analog_en_q,
  output logic                     conv_start_q,
  output logic      [CH_W-1:0]     conv_chan_q,
  input  wire logic                conv_done,
  input  wire logic [RES_W-1:0]    conv_data,
  output logic                     conv_event_q,
  output logic                     xfer_req_q,
  output logic      [WORD_W-1:0]   xfer_data_q,
  input  wire logic                xfer_ack
);

  // Register state
  logic              scan_q;
  logic              xfer_en_q;
  logic [CH_W-1:0]   first_ch_q;
  logic [CH_W-1:0]   analog_pin_select;
  logic [WORD_W-1:0] conversion_result_word;
  logic              done_q;
  logic              ovr_q;
  logic              go_q;

  // Sequencer outputs
  logic              seq_start;
  logic [CH_W-1:0]   seq_chan;
  logic              seq_busy;

  // Bus decode
  logic              setup;
  logic              access;
  logic              wr_acc;
  logic              rd_acc;
  logic              result_read;
  logic              status_clr;
  logic              flag_clear;

  // Address match used by read mux, write and side effects
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Left-justify a raw sample into the 16-bit word
  function automatic logic [WORD_W-1:0] justify(input logic [RES_W-1:0] d);
    return {d, {PAD_W{1'b0}}};
  endfunction

  // Known register offsets
  function automatic logic mapped(input logic [7:0] a);
    return reg_hit(a, OFF_CTRL) || reg_hit(a, OFF_PINSEL) ||
           reg_hit(a, OFF_STATUS) || reg_hit(a, OFF_RESULT);
  endfunction

  // Transfer phases; access completes in the cycle pready is high
  assign setup       = psel && !penable;
  assign access      = psel && penable && pready_q;
  assign wr_acc      = access && pwrite;
  assign rd_acc      = access && !pwrite;
  assign result_read = rd_acc && reg_hit(paddr, OFF_RESULT);
  assign status_clr  = wr_acc && reg_hit(paddr, OFF_STATUS) && pwdata[STAT_DONE_BIT];
  assign flag_clear  = result_read || status_clr || (xfer_req_q && xfer_ack);

  // Ready: one wait-free access cycle after every setup
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  // Error answer for unmapped offsets, raised with ready
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= setup && !mapped(paddr);
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= 32'h0000_0000;
      if (reg_hit(paddr, OFF_CTRL)) begin
        prdata_q[CTRL_SCAN_BIT]                <= scan_q;
        prdata_q[CTRL_XFER_BIT]                <= xfer_en_q;
        prdata_q[CTRL_CH_LSB +: CH_W]          <= first_ch_q;
      end else if (reg_hit(paddr, OFF_PINSEL)) begin
        prdata_q[CH_W-1:0]                     <= analog_pin_select;
      end else if (reg_hit(paddr, OFF_STATUS)) begin
        prdata_q[STAT_BUSY_BIT]                <= seq_busy;
        prdata_q[STAT_DONE_BIT]                <= done_q;
        prdata_q[STAT_OVR_BIT]                 <= ovr_q;
        prdata_q[STAT_CH_LSB +: CH_W]          <= seq_chan;
      end else if (reg_hit(paddr, OFF_RESULT)) begin
        prdata_q[WORD_W-1:0]                   <= conversion_result_word;
      end
    end
  end

  // Control register: mode, transfer enable, first channel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_q     <= 1'b0;
      xfer_en_q  <= 1'b0;
      first_ch_q <= CH_RST;
    end else if (wr_acc && reg_hit(paddr, OFF_CTRL)) begin
      scan_q     <= pwdata[CTRL_SCAN_BIT];
      xfer_en_q  <= pwdata[CTRL_XFER_BIT];
      first_ch_q <= pwdata[CTRL_CH_LSB +: CH_W];
    end
  end

  // Start is a write-one pulse, ignored while busy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      go_q <= 1'b0;
    end else begin
      go_q <= wr_acc && reg_hit(paddr, OFF_CTRL) && pwdata[CTRL_START_BIT] && !seq_busy;
    end
  end

  // Analog pin count; values above 24 make every channel analog
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      analog_pin_select <= PINSEL_RST;
    end else if (wr_acc && reg_hit(paddr, OFF_PINSEL)) begin
      analog_pin_select <= (pwdata[CH_W-1:0] > CH_W'(CH_COUNT)) ? CH_W'(CH_COUNT) :
                                                                  pwdata[CH_W-1:0]; // R1
    end
  end

  // Contiguous analog enable map
  adcs_pin_map u_pin_map (
    .clk               (clk),
    .rst               (rst),
    .analog_pin_select (analog_pin_select),
    .analog_en_q       (analog_en_q)
  );

  // Channel sequencer
  adcs_scan_seq u_seq (
    .clk       (clk),
    .rst       (rst),
    .go        (go_q),
    .scan      (scan_q),
    .first_ch  (first_ch_q),
    .conv_done (conv_done),
    .start_q   (seq_start),
    .chan_q    (seq_chan),
    .busy_q    (seq_busy)
  );

  // Start and channel to the analog core
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_start_q <= 1'b0;
      conv_chan_q  <= CH_RST;
    end else begin
      conv_start_q <= seq_start;
      conv_chan_q  <= seq_chan;
    end
  end

  // Single result word, overwritten by every conversion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conversion_result_word <= RESULT_RST;
    end else if (conv_done && seq_busy) begin
      conversion_result_word <= justify(conv_data); // R2
    end
  end

  // Completion pulse after each channel result lands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_event_q <= 1'b0;
    end else begin
      conv_event_q <= conv_done && seq_busy; // R6
    end
  end

  // Done flag: a new result wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (conv_event_q) begin
      done_q <= 1'b1; // R6
    end else if (flag_clear) begin
      done_q <= 1'b0;
    end
  end

  // Overrun: a result landed before the previous one was fetched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovr_q <= 1'b0;
    end else if (conv_event_q && done_q && !flag_clear) begin
      ovr_q <= 1'b1; // R4
    end else if (wr_acc && reg_hit(paddr, OFF_STATUS) && pwdata[STAT_OVR_BIT]) begin
      ovr_q <= 1'b0;
    end
  end

  // Transfer controller request held until acknowledged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xfer_req_q <= 1'b0;
    end else if (conv_event_q && xfer_en_q) begin
      xfer_req_q <= 1'b1; // R5
    end else if (xfer_ack) begin
      xfer_req_q <= 1'b0;
    end
  end

  // Word presented to the transfer controller
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xfer_data_q <= RESULT_RST;
    end else if (conv_event_q) begin
      xfer_data_q <= conversion_result_word; // R5
    end
  end

  a_result_left: assert property (@(posedge clk) disable iff (rst) // R2
    (conv_done && seq_busy) |=> conversion_result_word == {$past(conv_data), 6'h00})
    else $error("result word not left-justified sample");

  a_result_pad: assert property (@(posedge clk) disable iff (rst) // R2
    conversion_result_word[PAD_W-1:0] == 6'h00)
    else $error("low result bits not zero");

  a_event_after: assert property (@(posedge clk) disable iff (rst) // R6
    (conv_done && seq_busy) |=> conv_event_q ##1 done_q)
    else $error("no completion event after a result");

  a_xfer_copy: assert property (@(posedge clk) disable iff (rst) // R5
    (conv_event_q && xfer_en_q) |=> xfer_req_q && xfer_data_q == conversion_result_word)
    else $error("transfer request missing or wrong data");

  a_xfer_hold: assert property (@(posedge clk) disable iff (rst) // R5
    (xfer_req_q && !xfer_ack && !conv_event_q) |=> xfer_req_q && $stable(xfer_data_q))
    else $error("transfer request dropped before acknowledge");

  a_overrun_flag: assert property (@(posedge clk) disable iff (rst) // R4
    (conv_event_q && done_q && !flag_clear) |=> ovr_q)
    else $error("unfetched result did not raise overrun");

  a_en_map: assert property (@(posedge clk) disable iff (rst) // R1
    1'b1 |=> analog_en_q == (CH_COUNT'(1) << $past(analog_pin_select)) - CH_COUNT'(1))
    else $error("analog enable map not a block below the count");

  a_start_pulse: assert property (@(posedge clk) disable iff (rst) // R3
    conv_start_q |=> !conv_start_q)
    else $error("conversion start longer than one cycle");

  a_chan_hold: assert property (@(posedge clk) disable iff (rst) // R3
    (seq_busy && !conv_done) |=> $stable(seq_chan))
    else $error("channel moved while a conversion was pending");

  a_result_hold: assert property (@(posedge clk) disable iff (rst) // R4
    !(conv_done && seq_busy) |=> $stable(conversion_result_word))
    else $error("result word changed without a conversion");

  a_done_clear: assert property (@(posedge clk) disable iff (rst) // R4
    (result_read && !conv_event_q) |=> !done_q)
    else $error("result fetch did not clear the done flag");

  a_ovr_sticky: assert property (@(posedge clk) disable iff (rst) // R4
    (ovr_q && !(wr_acc && reg_hit(paddr, OFF_STATUS) && pwdata[STAT_OVR_BIT])) |=> ovr_q)
    else $error("overrun flag lost without a clear");

  a_xfer_drop: assert property (@(posedge clk) disable iff (rst) // R5
    (xfer_req_q && xfer_ack && !(conv_event_q && xfer_en_q)) |=> !xfer_req_q)
    else $error("transfer request kept after acknowledge");

  a_done_hold: assert property (@(posedge clk) disable iff (rst) // R6
    (done_q && !flag_clear) |=> done_q)
    else $error("done flag lost without a clear");

endmodule

// [adcs_core_model.sv]
// Far-side model: analog core answering each start, and a transfer
// controller that takes each offered result word.
// Assumes one clock shared with the converter control block.
`timescale 1ns/1ps
module adcs_core_model import adcs_pkg::*; (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             slow,
  input  wire logic             conv_start,
  input  wire logic [CH_W-1:0]  conv_chan,
  output logic                  conv_done,
  output logic      [RES_W-1:0] conv_data,
  input  wire logic             xfer_req,
  output logic                  xfer_ack
);
  logic            busy_q;
  logic [5:0]      cnt_q;
  logic [CH_W-1:0] ch_q;
  logic [2:0]      wait_q;

  // Conversion timing; data toggles outside the done cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q    <= 1'b0;
      cnt_q     <= 6'h00;
      ch_q      <= 5'h00;
      conv_done <= 1'b0;
      conv_data <= 10'h000;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        busy_q <= 1'b1;
        ch_q   <= conv_chan;
        cnt_q  <= slow ? 6'h28 : 6'h03;
      end else if (busy_q) begin
        if (cnt_q == 6'h00) begin
          conv_done <= 1'b1;
          conv_data <= {ch_q, ~ch_q};
          busy_q    <= 1'b0;
        end else begin
          cnt_q <= cnt_q - 6'h01;
        end
      end
    end
  end

  // Collect each offered word before the next lands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xfer_ack <= 1'b0;
      wait_q   <= 3'h0;
    end else begin
      xfer_ack <= 1'b0;
      if (xfer_req && !xfer_ack) begin
        if (wait_q == (slow ? 3'h5 : 3'h1)) begin
          xfer_ack <= 1'b1;
          wait_q   <= 3'h0;
        end else begin
          wait_q <= wait_q + 3'h1;
        end
      end
    end
  end
endmodule

// [testbench.sv]
// Self-checking bench for the converter control block over APB.
// Assumes the far-side model file is compiled before this one.
`timescale 1ns/1ps
module testbench import adcs_pkg::*;;
  logic              clk, rst, psel, penable, pwrite, slow;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata_q, d;
  logic              pready_q, pslverr_q, e, conv_start_q, conv_done;
  logic              conv_event_q, xfer_req_q, xfer_ack;
  logic [CH_COUNT-1:0] analog_en_q, en_exp;
  logic [CH_W-1:0]   conv_chan_q;
  logic [RES_W-1:0]  conv_data;
  logic [WORD_W-1:0] xfer_data_q;
  logic [4:0]        chq[$];
  logic [15:0]       xq[$];
  int                mismatches, checked, cycles, ev_cnt, base, nn;
  int                pins[4] = '{1, 5, 24, 31};

  adcs_top adcs_top_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .analog_en_q(analog_en_q),
    .conv_start_q(conv_start_q), .conv_chan_q(conv_chan_q), .conv_done(conv_done),
    .conv_data(conv_data), .conv_event_q(conv_event_q), .xfer_req_q(xfer_req_q),
    .xfer_data_q(xfer_data_q), .xfer_ack(xfer_ack));
  adcs_core_model adcs_core_model_inst (.clk(clk), .rst(rst), .slow(slow),
    .conv_start(conv_start_q), .conv_chan(conv_chan_q), .conv_done(conv_done),
    .conv_data(conv_data), .xfer_req(xfer_req_q), .xfer_ack(xfer_ack));

  // Clock of 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [15:0] exp_word(input logic [4:0] ch);
    return {ch, ~ch, 6'h00};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One APB transfer; waits for pready without assuming a count
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready_q !== 1'b1);
    d = prdata_q;
    e = pslverr_q;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_ev(input int n);
    for (int i = 0; i < 600 && ev_cnt < n; i++) @(posedge clk);
  endtask

  // Observers of the far-side traffic and the run limit
  always @(posedge clk) begin
    if (!rst && conv_start_q) chq.push_back(conv_chan_q);
    if (!rst && conv_event_q) ev_cnt++;
    if (!rst && xfer_ack && xfer_req_q) xq.push_back(xfer_data_q);
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    {rst, psel, penable, pwrite, slow} = 5'h10;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("en_reset", 32'(analog_en_q), 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check("reg_reset", d, 32'h0);
    end
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped_err", 32'(e), 32'h1);
    // Analog pins form one block from channel zero
    foreach (pins[i]) begin
      nn = (pins[i] > 24) ? 24 : pins[i];
      en_exp = (24'h000001 << nn) - 24'h000001;
      apb(1'b1, OFF_PINSEL, 32'(pins[i]));
      repeat (2) @(posedge clk);
      check("analog_en", 32'(analog_en_q), 32'(en_exp));
      apb(1'b0, OFF_PINSEL, 32'h0);
      check("pinsel_rd", d, 32'(nn));
    end
    // Single conversions, one clamped
    for (int i = 0; i < 2; i++) begin
      chq.delete();
      base = ev_cnt;
      apb(1'b1, OFF_CTRL, (i ? 32'd30 : 32'd7) << CTRL_CH_LSB | 32'h1);
      wait_ev(base + 1);
      check("single_event", 32'(ev_cnt), 32'(base + 1));
      check("single_ch", 32'(chq[0]), i ? 32'd23 : 32'd7);
      apb(1'b0, OFF_RESULT, 32'h0);
      check("single_word", d, 32'(exp_word(i ? 5'd23 : 5'd7)));
    end
    // Software scan, reading after every channel
    slow <= 1'b1;
    chq.delete();
    base = ev_cnt;
    apb(1'b1, OFF_CTRL, 32'd3 << CTRL_CH_LSB | 32'h3);
    for (int i = 0; i < 4; i++) begin
      wait_ev(base + i + 1);
      apb(1'b0, OFF_RESULT, 32'h0);
      check("scan_word", d, 32'(exp_word(5'(3 + i))));
      check("scan_ch", 32'(chq[i]), 32'(3 + i));
    end
    repeat (60) @(posedge clk);
    check("scan_count", 32'(chq.size()), 32'd4);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("no_overrun", d & 32'h7, 32'h0);
    // Unread fast scan leaves an overrun flag
    slow <= 1'b0;
    base = ev_cnt;
    apb(1'b1, OFF_CTRL, 32'd0 << CTRL_CH_LSB | 32'h3);
    wait_ev(base + 4);
    repeat (5) @(posedge clk);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("overrun", d & 32'h7, 32'h6);
    apb(1'b1, OFF_STATUS, 32'h6);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("flags_clear", d & 32'h6, 32'h0);
    // Transfer controller scan with clamped first channel
    chq.delete();
    xq.delete();
    base = ev_cnt;
    apb(1'b1, OFF_CTRL, 32'd22 << CTRL_CH_LSB | 32'h7);
    wait_ev(base + 4);
    repeat (20) @(posedge clk);
    check("xfer_count", 32'(xq.size()), 32'd4);
    for (int i = 0; i < 4; i++) begin
      check("xfer_word", 32'(xq[i]), 32'(exp_word(5'(20 + i))));
      check("xfer_ch", 32'(chq[i]), 32'(20 + i));
    end
    tally_and_finish();
  end
endmodule
